// ===== verilog/fspc_defines.svh
// Offsets, field positions, reset values and timing counts of the flash self-program control
`ifndef FSPC_DEFINES_SVH
`define FSPC_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define FSPC_ADDR_W 12
`define FSPC_CTRL_OFS 12'h000
`define FSPC_CTRL_RESET 8'h00
`define FSPC_BIT_IE 7
`define FSPC_BIT_SBUSY 6
`define FSPC_BIT_SIG 5
`define FSPC_BIT_RRE 4
`define FSPC_BIT_PROT 3
`define FSPC_BIT_PAGE_WRITE_CMD 2
`define FSPC_BIT_PAGE_ERASE_CMD 1
`define FSPC_BIT_ARM 0

// ****************************************
// Command patterns in the lower five bits
// ****************************************
`define FSPC_CMD_STORE 5'h01
`define FSPC_CMD_ERASE 5'h03
`define FSPC_CMD_WRITE 5'h05
`define FSPC_CMD_PROT 5'h09
`define FSPC_CMD_RRE 5'h11

// ****************************************
// Pointer layout and protection byte selects
// ****************************************
`define FSPC_PAGE_WORDS 32
`define FSPC_WORD_LSB 1
`define FSPC_WORD_MSB 5
`define FSPC_PAGE_LSB 6
`define FSPC_PAGE_W 10
`define FSPC_BUF_ERASED 16'hFFFF
`define FSPC_Z_FUSE_LOW 2'h0
`define FSPC_Z_LOCK 2'h1
`define FSPC_Z_FUSE_EXT 2'h2
`define FSPC_Z_FUSE_HIGH 2'h3

// ****************************************
// Timing
// ****************************************
`define FSPC_SPM_WIN 3'h4
`define FSPC_LPM_WIN 3'h3
`define FSPC_CLK_MHZ 100
`define FSPC_PROG_MIN_US 3700
`define FSPC_PROG_MAX_US 4500
`define FSPC_PROG_MIN_CYC (`FSPC_PROG_MIN_US * `FSPC_CLK_MHZ)
`define FSPC_PROG_MAX_CYC (`FSPC_PROG_MAX_US * `FSPC_CLK_MHZ)
`define FSPC_PROG_NOM_CYC ((`FSPC_PROG_MIN_CYC + `FSPC_PROG_MAX_CYC) / 2)
`define FSPC_TIMER_W 19

`endif

// ===== verilog/fspc_pkg.sv
// Types shared by the flash self-program control files
`include "fspc_defines.svh"

package fspc_pkg;

    typedef enum logic [1:0] {
        fspc_st_idle = 2'b00,
        fspc_st_armed = 2'b01,
        fspc_st_busy = 2'b11
    } fspc_state_type;

    typedef struct packed {
        logic spm;
        logic lpm;
        logic [15:0] z;
        logic [15:0] data;
    } fspc_cpu_req_type;

    typedef struct packed {
        logic erase;
        logic write;
        logic lock;
        logic [`FSPC_PAGE_W-1:0] page;
        logic [7:0] data;
    } fspc_flash_op_type;

endpackage

// ===== verilog/fspc_window.sv
// Short arming window counter, counted in clock cycles from its start pulse
`timescale 1ns/1ps
`include "fspc_defines.svh"

module fspc_window #(
    parameter logic [2:0] LENGTH = `FSPC_SPM_WIN
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    input wire logic stop,
    // Status
    output logic active,
    output logic expire
);
    logic [2:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 3'h0;
        end else if (start) begin
            cnt_q <= LENGTH;
        end else if (stop) begin
            cnt_q <= 3'h0;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end
    end

    assign active = cnt_q != 3'h0;
    // Last open cycle passes unused
    assign expire = (cnt_q == 3'h1) && !stop;
endmodule

// ===== verilog/fspc_timer.sv
// Programming duration timer for erase, page write and lock write
`timescale 1ns/1ps
`include "fspc_defines.svh"

module fspc_timer #(
    parameter int unsigned CYCLES = `FSPC_PROG_NOM_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic start,
    // Status
    output logic busy,
    output logic done
);
    localparam logic [`FSPC_TIMER_W-1:0] LOAD = `FSPC_TIMER_W'(CYCLES);
    logic [`FSPC_TIMER_W-1:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= LOAD;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - `FSPC_TIMER_W'(1);
        end
    end

    assign busy = cnt_q != '0;
    assign done = cnt_q == `FSPC_TIMER_W'(1);
endmodule

// ===== verilog/fspc_flash_self_program_control.sv
// Control and status logic for CPU-driven self-programming of program flash
//
// Contract
// [R01] Erase, page write and lock write each last between 3.7 ms and 4.5 ms.
// [R02] Section-busy bit 6 always reads zero.
// [R03] Ready interrupt requested while enabled, globally enabled and store arm clear.
// [R04] No ready interrupt during EEPROM write or flash programming.
// [R05] Signature select with arm: load within three cycles returns signature byte.
// [R06] Signature select with arm: store within four cycles does nothing.
// [R07] Writing section read re-enable clears the temporary page buffer.
// [R08] Protection access with arm: load within three cycles returns lock or fuse byte.
// [R09] Page write with arm: store within four cycles writes buffer to page.
// [R10] Page write bit clears on completion or after four idle cycles.
// [R11] CPU stalled for the whole page write or page erase.
// [R12] Page erase with arm: store within four cycles erases addressed page.
// [R13] Page erase bit clears on completion or after four idle cycles.
// [R14] Store arm enables the store instruction for four cycles only.
// [R15] Arm alone: store puts data word into buffer at pointer word, LSB ignored.
// [R16] Store arm clears after a store completes or four idle cycles.
// [R17] Store arm stays set until erase or page write finishes.
// [R18] Lower five bits other than the command patterns have no effect.
// [R19] Software uses pointer 1 lock, 0 low, 3 high, 2 extended fuse.
// [R20] Protection bits read zero when programmed, one when unprogrammed.
// [R21] EEPROM write blocks self-programming and protection bit reads.
// [R22] Arming windows count clock cycles from the register write.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "fspc_defines.svh"

module fspc_flash_self_program_control #(
    parameter int unsigned PROG_CYCLES = `FSPC_PROG_NOM_CYC,
    // Arbitrary neutral signature row contents
    parameter logic [31:0] SIGNATURE_ROW = 32'h1E2D3C4B
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`FSPC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU core
    input wire fspc_pkg::fspc_cpu_req_type cpu_req,
    input wire logic global_irq_enable,
    output logic cpu_halt,
    output logic store_ready_irq,
    output logic lpm_valid,
    output logic [7:0] lpm_data,
    // EEPROM status
    input wire logic eeprom_write_active,
    // Protection bytes
    input wire logic [7:0] lock_bits,
    input wire logic [7:0] fuse_low,
    input wire logic [7:0] fuse_high,
    input wire logic [7:0] fuse_ext,
    // Flash array
    output fspc_pkg::fspc_flash_op_type flash_op,
    input wire logic [4:0] buf_rd_idx,
    output logic [15:0] buf_rd_data
);
    import fspc_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    fspc_state_type state_q, state_d;
    logic ie_q, sig_q, rre_q, prot_q, page_write_cmd_q, page_erase_cmd_q, loaded_q, lpm_valid_q;
    logic [31:0] prdata_q;
    logic [15:0] buf_rd_q;
    fspc_flash_op_type flash_op_q;
    logic [15:0] page_buf [`FSPC_PAGE_WORDS];
    logic [`FSPC_TIMER_W-1:0] busy_len_q;
    logic addr_hit, apb_setup, apb_access, apb_write, sig_bit, cmd_store, cmd_sig, cmd_erase, cmd_write, cmd_prot;
    logic cmd_rre, cmd_ok, wr_accept, arm_load, arm_flag, in_armed, in_busy, spm_win_active, spm_win_expire;
    logic lpm_win_active, spm_hit, lpm_hit, timed_hit, store_hit, arm_end, cmd_clear, tmr_done, buf_clear;
    logic [4:0] low5;
    logic [7:0] lpm_data_q, ctrl_rd, prot_byte, sig_byte, lpm_sel;

    // ****************************************
    // APB register slave
    // ****************************************
    assign addr_hit = paddr == `FSPC_CTRL_OFS;
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign apb_write = apb_access && pwrite && addr_hit;
    assign pready = 1'b1;
    assign pslverr = apb_access && !addr_hit;
    assign prdata = prdata_q;

    assign ctrl_rd = {ie_q, 1'b0, sig_q, rre_q, prot_q, page_write_cmd_q, page_erase_cmd_q, arm_flag}; // R02 R17

    // Read data is sampled in the setup cycle so it comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (apb_setup && !pwrite) begin
            prdata_q <= addr_hit ? {24'h000000, ctrl_rd} : 32'h00000000;
        end
    end

    // ****************************************
    // Command decode
    // ****************************************
    assign low5 = pwdata[4:0];
    assign sig_bit = pwdata[`FSPC_BIT_SIG];
    assign cmd_store = (low5 == `FSPC_CMD_STORE) && !sig_bit;
    assign cmd_sig = (low5 == `FSPC_CMD_STORE) && sig_bit;
    assign cmd_erase = low5 == `FSPC_CMD_ERASE;
    assign cmd_write = low5 == `FSPC_CMD_WRITE;
    assign cmd_prot = low5 == `FSPC_CMD_PROT;
    assign cmd_rre = low5 == `FSPC_CMD_RRE;
    assign cmd_ok = cmd_store || cmd_sig || cmd_erase || cmd_write || cmd_prot || cmd_rre; // R18
    // A pending EEPROM write locks out every flash command and protection read
    assign wr_accept = apb_write && (state_q == fspc_st_idle) && !eeprom_write_active; // R21
    assign arm_load = wr_accept && cmd_ok; // R18

    // ****************************************
    // Arming windows and timer
    // ****************************************
    fspc_window #(
        .LENGTH(`FSPC_SPM_WIN)
    ) u_spm_win (
        .pclk(pclk),
        .presetn(presetn),
        .start(arm_load), // R14 R22
        .stop(spm_hit || lpm_hit),
        .active(spm_win_active),
        .expire(spm_win_expire)
    );

    fspc_window #(
        .LENGTH(`FSPC_LPM_WIN)
    ) u_lpm_win (
        .pclk(pclk),
        .presetn(presetn),
        .start(arm_load && (cmd_prot || cmd_sig)), // R22
        .stop(spm_hit || lpm_hit),
        .active(lpm_win_active),
        .expire()
    );

    fspc_timer #(
        .CYCLES(PROG_CYCLES)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(timed_hit), // R01
        .busy(),
        .done(tmr_done)
    );

    // ****************************************
    // Sequencer
    // ****************************************
    assign arm_flag = state_q != fspc_st_idle;
    assign in_armed = state_q == fspc_st_armed;
    assign in_busy = state_q == fspc_st_busy;
    // An EEPROM write that starts inside a window still blocks the instruction
    assign spm_hit = in_armed && cpu_req.spm && spm_win_active && !eeprom_write_active; // R21
    assign lpm_hit = in_armed && cpu_req.lpm && lpm_win_active && (prot_q || sig_q) && !eeprom_write_active; // R05 R08
    assign timed_hit = spm_hit && (page_erase_cmd_q || page_write_cmd_q || prot_q); // R09 R12
    assign store_hit = spm_hit && !(page_erase_cmd_q || page_write_cmd_q || prot_q || sig_q || rre_q); // R15
    // Signature and re-enable stores simply complete with no flash action
    assign arm_end = spm_win_expire || lpm_hit || (spm_hit && !timed_hit); // R06 R16
    assign cmd_clear = arm_flag && (state_d == fspc_st_idle); // R10 R13

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            fspc_st_idle: begin
                if (arm_load) begin
                    state_d = fspc_st_armed;
                end
            end
            fspc_st_armed: begin
                if (timed_hit) begin
                    state_d = fspc_st_busy;
                end else if (arm_end) begin
                    state_d = fspc_st_idle;
                end
            end
            fspc_st_busy: begin
                if (tmr_done) begin
                    state_d = fspc_st_idle; // R17
                end
            end
            default: begin
                state_d = fspc_st_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= fspc_st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ie_q, sig_q, rre_q, prot_q, page_write_cmd_q, page_erase_cmd_q} <= 6'h00;
        end else begin
            if (apb_write) begin
                ie_q <= pwdata[`FSPC_BIT_IE];
            end
            if (arm_load) begin
                {sig_q, rre_q, prot_q, page_write_cmd_q, page_erase_cmd_q} <= {cmd_sig, cmd_rre, cmd_prot, cmd_write, cmd_erase};
            end else if (cmd_clear) begin
                {sig_q, rre_q, prot_q, page_write_cmd_q, page_erase_cmd_q} <= 5'h00; // R10 R13
            end
        end
    end

    // ****************************************
    // CPU side outputs
    // ****************************************
    assign cpu_halt = in_busy && (page_erase_cmd_q || page_write_cmd_q); // R11
    // Arm flag already covers busy programming, so only EEPROM needs a term
    assign store_ready_irq = ie_q && global_irq_enable && !arm_flag && !eeprom_write_active; // R03 R04

    // Protection bytes pass unchanged: programmed bits already arrive as zero
    assign prot_byte = (cpu_req.z[1:0] == `FSPC_Z_LOCK) ? lock_bits : // R19 R20
                       (cpu_req.z[1:0] == `FSPC_Z_FUSE_HIGH) ? fuse_high :
                       (cpu_req.z[1:0] == `FSPC_Z_FUSE_EXT) ? fuse_ext : fuse_low;
    assign sig_byte = (cpu_req.z[2:1] == 2'h0) ? SIGNATURE_ROW[7:0] :
                      (cpu_req.z[2:1] == 2'h1) ? SIGNATURE_ROW[15:8] :
                      (cpu_req.z[2:1] == 2'h2) ? SIGNATURE_ROW[23:16] : SIGNATURE_ROW[31:24];
    assign lpm_sel = prot_q ? prot_byte : sig_byte; // R05 R08
    assign lpm_valid = lpm_valid_q;
    assign lpm_data = lpm_data_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lpm_valid_q <= 1'b0;
            lpm_data_q <= 8'h00;
        end else begin
            lpm_valid_q <= lpm_hit;
            if (lpm_hit) begin
                lpm_data_q <= lpm_sel;
            end
        end
    end

    // ****************************************
    // Flash operation start
    // ****************************************
    assign flash_op = flash_op_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_op_q <= '0;
        end else begin
            flash_op_q.erase <= timed_hit && page_erase_cmd_q; // R12
            flash_op_q.write <= timed_hit && page_write_cmd_q; // R09
            flash_op_q.lock <= timed_hit && prot_q;
            if (timed_hit) begin
                flash_op_q.page <= cpu_req.z[15:`FSPC_PAGE_LSB];
                flash_op_q.data <= cpu_req.data[7:0];
            end
        end
    end

    // ****************************************
    // Temporary page buffer
    // ****************************************
    // An EEPROM write during page loading loses the loaded words
    assign buf_clear = (wr_accept && cmd_rre) || (tmr_done && page_write_cmd_q) || (eeprom_write_active && loaded_q); // R07
    assign buf_rd_data = buf_rd_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < `FSPC_PAGE_WORDS; i++) begin
                page_buf[i] <= `FSPC_BUF_ERASED;
            end
            loaded_q <= 1'b0;
        end else if (buf_clear) begin
            for (int i = 0; i < `FSPC_PAGE_WORDS; i++) begin
                page_buf[i] <= `FSPC_BUF_ERASED;
            end
            loaded_q <= 1'b0;
        end else if (store_hit) begin
            page_buf[cpu_req.z[`FSPC_WORD_MSB:`FSPC_WORD_LSB]] <= cpu_req.data; // R15
            loaded_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_rd_q <= 16'h0000;
        end else begin
            buf_rd_q <= page_buf[buf_rd_idx];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_len_q <= '0;
        end else if (in_busy) begin
            busy_len_q <= busy_len_q + `FSPC_TIMER_W'(1);
        end else begin
            busy_len_q <= '0;
        end
    end

    sequence quiet4_s;
        (!cpu_req.spm && !cpu_req.lpm && !apb_write) [*4];
    endsequence

    sequence quiet3_s;
        (!cpu_req.spm && !cpu_req.lpm && !apb_write) [*3];
    endsequence

    prog_time_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        tmr_done |-> (busy_len_q == `FSPC_TIMER_W'(PROG_CYCLES - 1)))
        else $error("programming time differs from the timer setting");
    sec_busy_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
        (apb_access && !pwrite && addr_hit) |-> !prdata[`FSPC_BIT_SBUSY])
        else $error("section busy bit read as one");
    irq_when_idle_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        (ie_q && global_irq_enable && !arm_flag && !eeprom_write_active) |-> store_ready_irq)
        else $error("ready interrupt missing");
    irq_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
        (eeprom_write_active || in_busy) |-> !store_ready_irq)
        else $error("ready interrupt raised while busy");
    sig_spm_nop_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
        (spm_hit && sig_q) |=> (state_q == fspc_st_idle) && !flash_op.erase && !flash_op.write)
        else $error("signature store did something");
    rre_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
        (wr_accept && cmd_rre) |=> !loaded_q)
        else $error("page buffer not cleared");

    prot_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R08
        (lpm_hit && prot_q) |=> lpm_valid && (lpm_data == $past(prot_byte)))
        else $error("protection byte not returned");

    lpm_late_a: assert property (@(posedge pclk) disable iff (!presetn) // R22
        (arm_load && cmd_prot) ##1 quiet3_s ##1 cpu_req.lpm |=> !lpm_valid)
        else $error("load accepted after its window");

    halt_busy_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (timed_hit && (page_write_cmd_q || page_erase_cmd_q)) |=> cpu_halt [*8])
        else $error("cpu not halted during programming");

    arm_expire_a: assert property (@(posedge pclk) disable iff (!presetn) // R14
        arm_load ##1 quiet4_s |=> (state_q == fspc_st_idle) && !page_write_cmd_q && !page_erase_cmd_q)
        else $error("arm window longer than four cycles");

    arm_busy_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
        in_busy |-> ctrl_rd[`FSPC_BIT_ARM])
        else $error("arm flag dropped while busy");

    bad_cmd_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
        (apb_write && !cmd_ok && (state_q == fspc_st_idle)) |=> (state_q == fspc_st_idle))
        else $error("invalid pattern armed a command");

    ee_block_a: assert property (@(posedge pclk) disable iff (!presetn) // R21
        (eeprom_write_active && (state_q == fspc_st_idle)) |=> (state_q == fspc_st_idle))
        else $error("command armed during eeprom write");
endmodule

// ===== test/fspc_cpu_model.sv
// CPU core model issuing store and load program instructions
`timescale 1ns/1ps
module fspc_cpu_model (
    // Clock
    input wire logic pclk,
    // Core status
    input wire logic cpu_halt,
    input wire logic lpm_valid,
    input wire logic [7:0] lpm_data,
    // Instruction strobes and loaded byte
    output fspc_pkg::fspc_cpu_req_type cpu_req,
    output logic [7:0] load_byte
);
    import fspc_pkg::*;

    initial cpu_req = '0;
    initial load_byte = 8'h00;

    always @(posedge pclk) begin
        if (lpm_valid === 1'b1) begin
            load_byte <= lpm_data;
        end
    end

    // Pointer and data are scrambled after the pulse so stale values never pass for live ones
    task automatic exec(input int d, input logic s, input logic [15:0] z, input logic [15:0] w);
        repeat (d) @(posedge pclk);
        while (cpu_halt === 1'b1) @(posedge pclk);
        cpu_req <= {s, !s, z, w};
        @(posedge pclk);
        cpu_req <= {1'b0, 1'b0, ~z, ~w};
    endtask
endmodule

// ===== test/tb_flash_self_program_control.sv
// Self-checking bench for the flash self-program control
`timescale 1ns/1ps
module tb_flash_self_program_control;
    import fspc_pkg::*;
    // Arbitrary signature row contents
    localparam logic [31:0] SIG = 32'h6B5A4938;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, gie, cpu_halt, irq, lpm_valid, eew;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0] lpm_data;
    logic [7:0] pv [4];
    logic [4:0] buf_rd_idx;
    logic [15:0] buf_rd_data;
    logic [9:0] pg;
    logic e;
    fspc_cpu_req_type cpu_req;
    fspc_flash_op_type flash_op;
    int error_cnt = 0, total_checks = 0, cyc = 0, n_halt = 0, n_er = 0, n_wr = 0, n_lk = 0;

    fspc_flash_self_program_control #(.PROG_CYCLES(20), .SIGNATURE_ROW(SIG)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_req(cpu_req), .global_irq_enable(gie), .cpu_halt(cpu_halt), .store_ready_irq(irq),
        .lpm_valid(lpm_valid), .lpm_data(lpm_data), .eeprom_write_active(eew),
        .lock_bits(pv[1]), .fuse_low(pv[0]), .fuse_high(pv[3]), .fuse_ext(pv[2]),
        .flash_op(flash_op), .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data));

    fspc_cpu_model cpu (.pclk(pclk), .cpu_halt(cpu_halt), .lpm_valid(lpm_valid),
        .lpm_data(lpm_data), .cpu_req(cpu_req), .load_byte());

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Event counters and hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        n_halt <= n_halt + (cpu_halt === 1'b1);
        n_er <= n_er + (flash_op.erase === 1'b1);
        n_wr <= n_wr + (flash_op.write === 1'b1);
        n_lk <= n_lk + (flash_op.lock === 1'b1);
        if (flash_op.erase === 1'b1 || flash_op.write === 1'b1) pg <= flash_op.page;
        if (cyc == 3000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, s, x);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] d);
        apb(1'b1, 12'h000, d);
    endtask

    task automatic rdchk(input logic [7:0] x);
        apb(1'b0, 12'h000, 8'h00);
        chk(r, {24'h0, x});
    endtask

    task automatic bufchk(input logic [4:0] i, input logic [15:0] x);
        buf_rd_idx <= i;
        repeat (2) @(posedge pclk);
        chk(buf_rd_data, x);
    endtask

    task automatic halt_wait;
        repeat (2) @(posedge pclk);
        while (cpu_halt === 1'b1) @(posedge pclk);
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        logic [7:0] cm [3];
        cm = '{8'h81, 8'h83, 8'h85};
        pv = '{8'h3C, 8'hE2, 8'hD9, 8'hFD};
        {presetn, psel, penable, pwrite, gie, eew, paddr, pwdata, buf_rd_idx} = '0;
        gie = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(8'h00);
        apb(1'b0, 12'h004, 8'h00);
        chk(e, 1'b1);
        wr(8'hFF);
        rdchk(8'h80);
        chk(irq, 1'b1);
        gie <= 1'b0;
        @(posedge pclk);
        chk(irq, 1'b0);
        gie <= 1'b1;
        eew <= 1'b1;
        @(posedge pclk);
        chk(irq, 1'b0);
        wr(8'h83);
        rdchk(8'h80);
        eew <= 1'b0;
        wr(8'h81);
        cpu.exec(3, 1'b1, 16'h0007, 16'hA5C3);
        bufchk(3, 16'hA5C3);
        wr(8'h91);
        bufchk(3, 16'hFFFF);
        foreach (cm[i]) begin
            wr(cm[i]);
            repeat (4) @(posedge pclk);
            rdchk(8'h80);
            cpu.exec(0, 1'b1, 16'h0009, 16'h1234);
        end
        bufchk(4, 16'hFFFF);
        wr(8'h83);
        cpu.exec(0, 1'b1, 16'h0140, 16'h0000);
        rdchk(8'h83);
        chk(irq, 1'b0);
        halt_wait();
        chk(n_halt, 20);
        chk(n_er, 1);
        chk(pg, 10'd5);
        rdchk(8'h80);
        wr(8'h81);
        cpu.exec(0, 1'b1, 16'h0000, 16'h5A5A);
        wr(8'h85);
        cpu.exec(1, 1'b1, 16'h0280, 16'hFFFF);
        halt_wait();
        chk(n_wr, 1);
        chk(pg, 10'd10);
        chk(n_halt, 40);
        bufchk(0, 16'hFFFF);
        for (int i = 0; i < 4; i++) begin
            wr(8'h89);
            cpu.exec((i == 3) ? 2 : 0, 1'b0, i[15:0], 16'h0000);
            repeat (2) @(posedge pclk);
            chk(cpu.load_byte, pv[i]);
        end
        wr(8'h89);
        cpu.exec(3, 1'b0, 16'h0000, 16'h0000);
        repeat (2) @(posedge pclk);
        chk(cpu.load_byte, pv[3]);
        wr(8'h89);
        cpu.exec(0, 1'b1, 16'h0001, 16'h0000);
        repeat (30) @(posedge pclk);
        chk(n_lk, 1);
        chk(n_halt, 40);
        wr(8'hA1);
        cpu.exec(0, 1'b0, 16'h0002, 16'h0000);
        repeat (2) @(posedge pclk);
        chk(cpu.load_byte, SIG[15:8]);
        wr(8'hA1);
        cpu.exec(0, 1'b1, 16'h0040, 16'h7777);
        bufchk(0, 16'hFFFF);
        rdchk(8'h80);
        chk(n_er + n_wr, 2);
        final_report();
    end
endmodule
